// *** logic/lcdsr_pkg.sv ***
// Constants for the three-wire serial receive path and reset sequencer.
// Assumes a 100 MHz system clock and a host-driven serial clock.
package lcdsr_pkg;
    // -----------------------------------------------------------------
    // Memory and defaults
    // -----------------------------------------------------------------
    localparam int TEXT_DEPTH = 128;
    localparam int TEXT_AW = 7;
    localparam logic [7:0] BLANK_CHAR = 8'h20;
    localparam logic [6:0] DATA_LEN_RST = 7'h00;
    localparam logic [6:0] DATA_LEN_MAX = 7'h4f;
    // Data-length instruction: top bit set, low seven bits count
    localparam int DLEN_FLAG_BIT = 7;
    localparam logic DEF_BUS_8BIT = 1'b1;
    localparam logic DEF_INC = 1'b1;
    localparam logic [3:0] DEF_SCROLL = 4'h0;
    // -----------------------------------------------------------------
    // Scan duty: common count per frame
    // -----------------------------------------------------------------
    localparam logic [5:0] DUTY_TWO_LINE = 6'h11;
    localparam logic [5:0] DUTY_FOUR_LINE = 6'h21;
    // Power-on reset stretch
    localparam int POR_NS = 1000;
    localparam int CLK_MHZ = 100;
    localparam int POR_CYCLES = (POR_NS * CLK_MHZ + 999) / 1000;
    typedef enum logic [2:0] {
        LCDSR_IDLE  = 3'b001,
        LCDSR_CLEAR = 3'b010,
        LCDSR_DONE  = 3'b100
    } lcdsr_state_t;
endpackage : lcdsr_pkg

// *** logic/lcdsr_shift.sv ***
// Serial byte shifter on the host's serial clock.
// Assumes the host idles the clock high and frames with an active-low
// select; a toggle tells the system domain a byte is ready.
`timescale 1ns/10ps
module lcdsr_shift import lcdsr_pkg::*; (
    // Link
    input wire logic i_sclk,
    input wire logic i_resetn,
    input wire logic i_serial_select_n,
    input wire logic i_serial_in_line,
    // Byte out
    output logic [7:0] o_byte,
    output logic o_toggle
);
    logic [6:0] sh_r;
    logic [6:0] sh_nxt;
    logic [2:0] cnt_r;
    logic [2:0] cnt_nxt;
    logic [7:0] byte_r;
    logic [7:0] byte_nxt;
    logic tog_r;
    logic tog_nxt;

    // Select high clears the bit count asynchronously, since the clock
    // may not tick between frames.
    always_comb begin
        sh_nxt = {sh_r[5:0], i_serial_in_line}; // see RULE_05
        cnt_nxt = cnt_r + 3'h1;
        byte_nxt = byte_r;
        tog_nxt = tog_r;
        if (cnt_r == 3'h7) begin
            byte_nxt = {sh_r, i_serial_in_line};
            tog_nxt = ~tog_r;
        end
    end

    always_ff @(posedge i_sclk or negedge i_resetn) begin
        if (!i_resetn) begin
            sh_r <= 7'h00;
            byte_r <= 8'h00;
            tog_r <= 1'b0;
        end else if (!i_serial_select_n) begin
            sh_r <= sh_nxt;
            byte_r <= byte_nxt;
            tog_r <= tog_nxt;
        end
    end

    always_ff @(posedge i_sclk or posedge i_serial_select_n) begin
        if (i_serial_select_n) begin
            cnt_r <= 3'h0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign o_byte = byte_r;
    assign o_toggle = tog_r;
endmodule : lcdsr_shift

// *** logic/lcdsr_ctrl.sv ***
// Three-wire serial host receiver with reset initialisation and
// common-scan duty counter.
// Assumes i_resetn is the power-on reset and the link clock is
// unrelated to i_clk.
`timescale 1ns/10ps
// Notes on behaviour
// RULE_01 - Three-wire link: select, data and clock only; no instruction/data select line.
// RULE_02 - Pending data count splits instruction bytes from data bytes.
// RULE_03 - Host sends data-length instruction, then that many data bytes.
// RULE_04 - Host keeps the serial clock high when idle.
// RULE_05 - Serial data sampled on serial clock rising edge while selected.
// RULE_06 - Power-on reset runs the initialisation without host action.
// RULE_07 - Busy flag high throughout initialisation, low only at its end.
// RULE_08 - First step fills all text memory with code 20h.
// RULE_09 - Defaults: 8-bit bus, no extended access, no blink, bank 0.
// RULE_10 - Display, cursor and cursor blink start off.
// RULE_11 - Entry: increment by one, no shift, normal segment order.
// RULE_12 - 5-dot fonts, normal cursor; four-line select keeps line mode.
// RULE_13 - All four per-line scroll enables cleared.
// RULE_14 - Pending data count reset to zero, one data byte expected.
// RULE_15 - Hardware reset low repeats the power-on initialisation.
// RULE_16 - Hardware reset ignored while power-on initialisation runs.
// RULE_17 - Scan duty 1/17 in two-line mode, 1/33 in four-line mode.
// RULE_18 - Count N announces N plus one data bytes, up to eighty.
// RULE_19 - Host waits for busy flag low before next instruction.
// RULE_20 - Serial mode when port type select low, parallel when high.
// RULE_21 - After the announced bytes the next byte is an instruction.
module lcdsr_ctrl import lcdsr_pkg::*; #(
    parameter int DEPTH = TEXT_DEPTH
) (
    // System
    input wire logic i_clk,
    input wire logic i_resetn,
    // Pins
    input wire logic i_hw_reset_n,
    input wire logic i_port_type_sel,
    input wire logic i_four_line_sel,
    // Serial link
    input wire logic i_sclk,
    input wire logic i_serial_select_n,
    input wire logic i_serial_in_line,
    // Received bytes
    output logic o_instr_valid,
    output logic o_data_valid,
    output logic [7:0] o_rx_byte,
    // Status and settings
    output logic o_busy_flag,
    output logic o_text_clear_we,
    output logic [TEXT_AW-1:0] o_text_clear_addr,
    output logic [7:0] o_text_clear_data,
    output logic o_bus_8bit,
    output logic o_ext_reg_access,
    output logic o_user_font_blink,
    output logic o_code_bank_sel,
    output logic o_reverse_video,
    output logic o_display_on,
    output logic o_cursor_on,
    output logic o_cursor_blink,
    output logic o_addr_inc,
    output logic o_display_shift,
    output logic o_segment_order,
    output logic o_font_width_sel,
    output logic o_cursor_style,
    output logic [3:0] o_line_scroll_en,
    output logic [6:0] o_pending_data_count,
    output logic o_serial_mode,
    output logic [5:0] o_common_index,
    output logic o_frame_start
);
    // -----------------------------------------------------------------
    // Link domain
    // -----------------------------------------------------------------
    logic [7:0] link_byte;
    logic link_tog;
    logic link_rstn;

    // Link shift, byte and toggle registers are held in reset while the parallel port is selected
    assign link_rstn = i_resetn & ~i_port_type_sel; // see RULE_20

    lcdsr_shift u_shift (
        .i_sclk(i_sclk),
        .i_resetn(link_rstn),
        .i_serial_select_n(i_serial_select_n),
        .i_serial_in_line(i_serial_in_line),
        .o_byte(link_byte),
        .o_toggle(link_tog)
    ); // see RULE_01

    // -----------------------------------------------------------------
    // Synchronisers
    // -----------------------------------------------------------------
    logic tog_s1_r;
    logic tog_s2_r;
    logic tog_s3_r;
    logic hw_s1_r;
    logic hw_s2_r;
    logic ps_s1_r;
    logic ps_s2_r;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            tog_s1_r <= 1'b0;
            tog_s2_r <= 1'b0;
            tog_s3_r <= 1'b0;
            hw_s1_r <= 1'b1;
            hw_s2_r <= 1'b1;
            ps_s1_r <= 1'b0;
            ps_s2_r <= 1'b0;
        end else begin
            tog_s1_r <= link_tog;
            tog_s2_r <= tog_s1_r;
            tog_s3_r <= tog_s2_r;
            hw_s1_r <= i_hw_reset_n;
            hw_s2_r <= hw_s1_r;
            ps_s1_r <= i_port_type_sel;
            ps_s2_r <= ps_s1_r;
        end
    end

    logic byte_evt;
    // Byte moves with the toggle, then holds for a whole byte time
    assign byte_evt = (tog_s2_r ^ tog_s3_r) & ~ps_s2_r;

    // -----------------------------------------------------------------
    // Initialisation sequencer
    // -----------------------------------------------------------------
    lcdsr_state_t st_r;
    lcdsr_state_t st_nxt;
    logic [TEXT_AW-1:0] addr_r;
    logic [TEXT_AW-1:0] addr_nxt;
    logic por_r;
    logic por_nxt;
    logic [15:0] wait_r;
    logic [15:0] wait_nxt;
    logic hw_req;

    // Hardware reset is ignored while the power-on pass runs
    assign hw_req = ~hw_s2_r & ~por_r; // see RULE_16

    always_comb begin
        st_nxt = st_r;
        addr_nxt = addr_r;
        por_nxt = por_r;
        wait_nxt = wait_r;
        case (st_r)
            LCDSR_IDLE: begin
                // Power-on stretch before the clear starts
                if (wait_r == 16'(POR_CYCLES - 1)) begin
                    st_nxt = LCDSR_CLEAR; // see RULE_06
                    addr_nxt = '0;
                end else begin
                    wait_nxt = wait_r + 16'h1;
                end
            end
            LCDSR_CLEAR: begin
                if (addr_r == TEXT_AW'(DEPTH - 1)) begin
                    st_nxt = LCDSR_DONE;
                    por_nxt = 1'b0;
                end else begin
                    addr_nxt = addr_r + 1'b1; // see RULE_08
                end
            end
            LCDSR_DONE: begin
                if (hw_req) begin
                    st_nxt = LCDSR_CLEAR; // see RULE_15
                    addr_nxt = '0;
                end
            end
            default: begin
                st_nxt = LCDSR_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_r <= LCDSR_IDLE;
            addr_r <= '0;
            por_r <= 1'b1;
            wait_r <= 16'h0;
        end else begin
            st_r <= st_nxt;
            addr_r <= addr_nxt;
            por_r <= por_nxt;
            wait_r <= wait_nxt;
        end
    end

    logic init_busy;
    assign init_busy = (st_r != LCDSR_DONE);
    assign o_busy_flag = init_busy; // see RULE_07
    assign o_text_clear_we = (st_r == LCDSR_CLEAR);
    assign o_text_clear_addr = addr_r;
    assign o_text_clear_data = BLANK_CHAR; // see RULE_08

    // -----------------------------------------------------------------
    // Settings loaded with their defaults on each initialisation
    // -----------------------------------------------------------------
    logic [6:0] dlen_r;
    logic [6:0] dlen_nxt;
    logic [6:0] left_r;
    logic [6:0] left_nxt;
    logic in_data_r;
    logic in_data_nxt;
    logic iv_r;
    logic iv_nxt;
    logic dv_r;
    logic dv_nxt;
    logic [7:0] rx_r;
    logic [7:0] rx_nxt;

    always_comb begin
        dlen_nxt = dlen_r;
        left_nxt = left_r;
        in_data_nxt = in_data_r;
        iv_nxt = 1'b0;
        dv_nxt = 1'b0;
        rx_nxt = rx_r;
        if (init_busy) begin
            dlen_nxt = DATA_LEN_RST; // see RULE_14
            in_data_nxt = 1'b0;
            left_nxt = 7'h0;
        end else if (byte_evt) begin
            rx_nxt = link_byte;
            // Mode decided by pending count, never by a select line
            if (in_data_r) begin // see RULE_02
                dv_nxt = 1'b1;
                if (left_r == 7'h0) begin
                    in_data_nxt = 1'b0; // see RULE_21
                end else begin
                    left_nxt = left_r - 7'h1;
                end
            end else begin
                iv_nxt = 1'b1;
                if (link_byte[DLEN_FLAG_BIT]) begin
                    // Oversized counts clamp at eighty bytes
                    if (link_byte[6:0] > DATA_LEN_MAX) begin
                        dlen_nxt = DATA_LEN_MAX; // see RULE_18
                    end else begin
                        dlen_nxt = link_byte[6:0];
                    end
                    left_nxt = dlen_nxt;
                    in_data_nxt = 1'b1; // see RULE_03
                end
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            dlen_r <= DATA_LEN_RST;
            left_r <= 7'h0;
            in_data_r <= 1'b0;
            iv_r <= 1'b0;
            dv_r <= 1'b0;
            rx_r <= 8'h00;
        end else begin
            dlen_r <= dlen_nxt;
            left_r <= left_nxt;
            in_data_r <= in_data_nxt;
            iv_r <= iv_nxt;
            dv_r <= dv_nxt;
            rx_r <= rx_nxt;
        end
    end

    assign o_instr_valid = iv_r & ~init_busy;
    assign o_data_valid = dv_r & ~init_busy;
    assign o_rx_byte = rx_r;
    assign o_pending_data_count = dlen_r;
    assign o_serial_mode = ~ps_s2_r; // see RULE_20

    // Fixed defaults; instruction execution lies outside this block
    assign o_bus_8bit = DEF_BUS_8BIT; // see RULE_09
    assign o_ext_reg_access = 1'b0;
    assign o_user_font_blink = 1'b0;
    assign o_code_bank_sel = 1'b0;
    assign o_reverse_video = 1'b0;
    assign o_display_on = 1'b0; // see RULE_10
    assign o_cursor_on = 1'b0;
    assign o_cursor_blink = 1'b0;
    assign o_addr_inc = DEF_INC; // see RULE_11
    assign o_display_shift = 1'b0;
    assign o_segment_order = 1'b0;
    assign o_font_width_sel = 1'b0; // see RULE_12
    assign o_cursor_style = 1'b0;
    assign o_line_scroll_en = DEF_SCROLL; // see RULE_13

    // -----------------------------------------------------------------
    // Common scan counter
    // -----------------------------------------------------------------
    logic fl_s1_r;
    logic fl_s2_r;
    logic [5:0] com_r;
    logic [5:0] com_nxt;
    logic [5:0] duty;

    // Line mode pin held as is; it is a strap, synchronised anyway
    assign duty = fl_s2_r ? DUTY_FOUR_LINE : DUTY_TWO_LINE; // see RULE_17

    always_comb begin
        if (com_r >= duty - 6'h1) begin
            com_nxt = 6'h0;
        end else begin
            com_nxt = com_r + 6'h1;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            fl_s1_r <= 1'b0;
            fl_s2_r <= 1'b0;
            com_r <= 6'h0;
        end else begin
            fl_s1_r <= i_four_line_sel;
            fl_s2_r <= fl_s1_r;
            com_r <= com_nxt;
        end
    end

    assign o_common_index = com_r;
    assign o_frame_start = (com_r == 6'h0);
endmodule : lcdsr_ctrl

// *** test/lcdsr_chk.sv ***
// Checker for the reset sequencer, clear pass, byte pulses and scan.
// Bound onto lcdsr_ctrl; it sees that module's ports only.
`timescale 1ns/10ps
module lcdsr_chk import lcdsr_pkg::*; #(
    parameter int DEPTH = TEXT_DEPTH
) (
    // System
    input wire logic i_clk,
    input wire logic i_resetn,
    // Watched outputs
    input wire logic o_instr_valid,
    input wire logic o_data_valid,
    input wire logic o_busy_flag,
    input wire logic o_text_clear_we,
    input wire logic [TEXT_AW-1:0] o_text_clear_addr,
    input wire logic [7:0] o_text_clear_data,
    input wire logic [5:0] o_common_index
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    // -----------------------------------------------------------------
    // Clear writes counted over one busy pass
    // -----------------------------------------------------------------
    logic [7:0] clr_cnt_r;
    logic [7:0] clr_cnt_nxt;
    always_comb begin
        clr_cnt_nxt = 8'h00;
        if (o_busy_flag) clr_cnt_nxt = clr_cnt_r + {7'h00, o_text_clear_we};
    end
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) clr_cnt_r <= 8'h00;
        else clr_cnt_r <= clr_cnt_nxt;
    end
    // -----------------------------------------------------------------
    // Properties
    // -----------------------------------------------------------------
    sequence s_clr_pair;
        o_text_clear_we ##1 o_text_clear_we;
    endsequence
    property p_clr_busy;
        o_text_clear_we |-> o_busy_flag;
    endproperty
    a_clr_busy: assert property (p_clr_busy)
        else $error("clear write outside busy");
    property p_clr_data;
        o_text_clear_we |-> o_text_clear_data == BLANK_CHAR;
    endproperty
    a_clr_data: assert property (p_clr_data)
        else $error("clear data not blank");
    property p_clr_addr;
        s_clr_pair |-> o_text_clear_addr == $past(o_text_clear_addr) + 1'b1;
    endproperty
    a_clr_addr: assert property (p_clr_addr)
        else $error("clear address skipped");
    property p_busy_end;
        $fell(o_busy_flag) |-> clr_cnt_r == DEPTH;
    endproperty
    a_busy_end: assert property (p_busy_end)
        else $error("busy fell before clear pass finished");
    property p_drop;
        o_busy_flag |-> !(o_instr_valid || o_data_valid);
    endproperty
    a_drop: assert property (p_drop)
        else $error("byte delivered while busy");
    property p_pulse;
        (o_instr_valid || o_data_valid) |-> !(o_instr_valid && o_data_valid)
            ##1 !(o_instr_valid || o_data_valid);
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("byte pulse malformed");
    property p_step;
        o_common_index != 6'h00 |->
            o_common_index == $past(o_common_index) + 6'h01;
    endproperty
    a_step: assert property (p_step)
        else $error("common index skipped");
    property p_wrap;
        (o_common_index == 6'h00 && $past(o_common_index) != 6'h00) |->
            ($past(o_common_index) == DUTY_TWO_LINE - 6'h01 ||
             $past(o_common_index) == DUTY_FOUR_LINE - 6'h01);
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("common scan wrapped at wrong count");
endmodule : lcdsr_chk

// *** test/lcdsr_host.sv ***
// Host serial master model for the three-wire link.
// Its clock idles high and stands still between bytes.
`timescale 1ns/10ps
module lcdsr_host (
    // Three-wire link
    output logic o_sclk,
    output logic o_serial_select_n,
    output logic o_serial_in_line
);
    initial begin
        o_sclk = 1'b1;
        o_serial_select_n = 1'b1;
        o_serial_in_line = 1'b1;
    end
    // Data moves while the clock is low, so every rise sees it settled
    task send(input logic [7:0] b, input int nb);
        #3.7;
        o_serial_select_n = 1'b0;
        for (int i = 7; i > 7 - nb; i--) begin
            #15;
            o_sclk = 1'b0;
            o_serial_in_line = b[i];
            #15;
            o_sclk = 1'b1;
        end
        #15;
        o_serial_select_n = 1'b1;
        // Released line shows the inverse, never a stale bit
        o_serial_in_line = ~o_serial_in_line;
        #60;
    endtask : send
endmodule : lcdsr_host

// *** test/lcdsr_ctrl_tb_top.sv ***
// Testbench for the serial receiver and reset sequencer.
// Pins change at the falling clock edge; the host model makes the link.
`timescale 1ns/10ps
module lcdsr_ctrl_tb_top import lcdsr_pkg::*;;
    logic i_clk, i_resetn, i_hw_reset_n, i_port_type_sel, i_four_line_sel;
    wire logic i_sclk, i_serial_select_n, i_serial_in_line;
    logic o_instr_valid, o_data_valid, o_busy_flag, o_text_clear_we;
    logic o_bus_8bit, o_ext_reg_access, o_user_font_blink, o_code_bank_sel;
    logic o_reverse_video, o_display_on, o_cursor_on, o_cursor_blink;
    logic o_addr_inc, o_display_shift, o_segment_order, o_font_width_sel;
    logic o_cursor_style, o_serial_mode, o_frame_start;
    logic [7:0] o_rx_byte, o_text_clear_data, last_b;
    logic [TEXT_AW-1:0] o_text_clear_addr;
    logic [3:0] o_line_scroll_en;
    logic [6:0] o_pending_data_count;
    logic [5:0] o_common_index;
    int mismatches = 0, checked = 0, n_iv = 0, n_dv = 0, n_clr = 0, n_bad = 0;
    lcdsr_ctrl #(.DEPTH(TEXT_DEPTH)) lcdsr_ctrl_i (.*);
    lcdsr_host lcdsr_host_i (.o_sclk(i_sclk),
        .o_serial_select_n(i_serial_select_n),
        .o_serial_in_line(i_serial_in_line));
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // -----------------------------------------------------------------
    // Monitors and helpers
    // -----------------------------------------------------------------
    // Sampled on the falling edge, half a cycle after outputs launch
    always @(negedge i_clk) begin
        if (o_instr_valid === 1'b1) n_iv++;
        if (o_data_valid === 1'b1) n_dv++;
        if ((o_instr_valid | o_data_valid) === 1'b1) last_b = o_rx_byte;
        if (o_text_clear_we === 1'b1) begin
            if (o_text_clear_addr !== n_clr[6:0]) n_bad++;
            if (o_text_clear_data !== BLANK_CHAR) n_bad++;
            n_clr++;
        end
    end
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask : cyc
    // Kind 0 expects nothing, 1 an instruction, 2 a data byte
    task xfer(input logic [7:0] b, input int nb, input int kind);
        int iv0, dv0;
        iv0 = n_iv;
        dv0 = n_dv;
        lcdsr_host_i.send(b, nb);
        cyc(20);
        chk("instr count", iv0 + (kind == 1), n_iv);
        chk("data count", dv0 + (kind == 2), n_dv);
        if (kind != 0) chk("rx byte", b, last_b);
    endtask : xfer
    task wait_idle;
        for (int i = 0; i < 1000 && o_busy_flag !== 1'b0; i++) cyc(1);
    endtask : wait_idle
    task report_and_stop;
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop
    // -----------------------------------------------------------------
    // Scenarios
    // -----------------------------------------------------------------
    task t_por;
        chk("busy", 1, o_busy_flag);
        cyc(20);
        i_hw_reset_n = 1'b0;
        cyc(5);
        i_hw_reset_n = 1'b1;
        wait_idle();
        chk("clear writes", TEXT_DEPTH, n_clr);
        chk("bad clears", 0, n_bad);
        chk("length", DATA_LEN_RST, o_pending_data_count);
        chk("func", {DEF_BUS_8BIT, 4'h0}, {o_bus_8bit, o_ext_reg_access,
            o_user_font_blink, o_code_bank_sel, o_reverse_video});
        chk("disp", 3'h0, {o_display_on, o_cursor_on, o_cursor_blink});
        chk("entry", {DEF_INC, 2'h0}, {o_addr_inc, o_display_shift,
            o_segment_order});
        chk("font", 2'h0, {o_font_width_sel, o_cursor_style});
        chk("scroll", DEF_SCROLL, o_line_scroll_en);
        chk("serial mode", 1, o_serial_mode);
        $display("test power-on done");
    endtask : t_por
    task t_dlen;
        xfer(8'h82, 8, 1);
        chk("length", 2, o_pending_data_count);
        for (int i = 0; i < 3; i++) xfer(8'hc5 + i[7:0], 8, 2);
        xfer(8'h01, 8, 1);
        $display("test data length done");
    endtask : t_dlen
    task t_hwrst;
        int n0;
        n0 = n_clr;
        i_hw_reset_n = 1'b0;
        cyc(4);
        i_hw_reset_n = 1'b1;
        cyc(4);
        chk("busy", 1, o_busy_flag);
        xfer(8'h33, 8, 0);
        wait_idle();
        chk("clear writes", n0 + TEXT_DEPTH, n_clr);
        chk("bad clears", 0, n_bad);
        chk("length", DATA_LEN_RST, o_pending_data_count);
        $display("test hardware reset done");
    endtask : t_hwrst
    task t_clamp;
        xfer(8'hff, 8, 1);
        chk("length", DATA_LEN_MAX, o_pending_data_count);
        for (int i = 0; i <= DATA_LEN_MAX; i++) xfer(i[7:0], 8, 2);
        xfer(8'h80, 8, 1);
        xfer(8'h90, 8, 2);
        xfer(8'h02, 8, 1);
        $display("test length limits done");
    endtask : t_clamp
    task t_misc;
        xfer(8'hf0, 4, 0);
        xfer(8'h3c, 8, 1);
        i_port_type_sel = 1'b1;
        cyc(5);
        chk("serial mode", 0, o_serial_mode);
        xfer(8'h11, 8, 0);
        i_port_type_sel = 1'b0;
        cyc(5);
        chk("serial mode", 1, o_serial_mode);
        xfer(8'h12, 8, 1);
        $display("test partial and port done");
    endtask : t_misc
    task t_duty;
        int n;
        for (int s = 0; s < 2; s++) begin
            i_four_line_sel = s[0];
            cyc(40);
            for (n = 0; n < 80 && o_frame_start !== 1'b1; n++) cyc(1);
            cyc(1);
            for (n = 1; n < 80 && o_frame_start !== 1'b1; n++) cyc(1);
            chk("frame", s ? DUTY_FOUR_LINE : DUTY_TWO_LINE, n);
        end
        $display("test duty done");
    endtask : t_duty
    initial begin
        i_resetn = 1'b0;
        i_hw_reset_n = 1'b1;
        i_port_type_sel = 1'b0;
        i_four_line_sel = 1'b0;
        cyc(12);
        i_resetn = 1'b1;
        t_por();
        t_dlen();
        t_hwrst();
        t_clamp();
        t_misc();
        t_duty();
        report_and_stop();
    end
    // Whole run needs about 55 us
    initial begin
        #200000;
        mismatches++;
        $display("watchdog expired");
        report_and_stop();
    end
endmodule : lcdsr_ctrl_tb_top
bind lcdsr_ctrl lcdsr_chk #(.DEPTH(DEPTH)) lcdsr_chk_i (.*);
